// ---- sqrt_abs_pkg.sv ----
// constants shared by the square-root/magnitude unit and its root core
// operands are single-precision binary floating-point words
package sqrt_abs_pkg;
	localparam int FLT_W = 32;
	localparam logic [7:0] EXP_SPECIAL = 8'hFF;
	localparam logic [7:0] EXP_BIAS = 8'h7F;
	localparam logic [9:0] EXP_BIAS_W = 10'h07F;
	localparam logic [31:0] LOW_CUT_DEFAULT = 32'h00000000;
	localparam logic [31:0] GAIN_DEFAULT = 32'h41200000;
	localparam logic [31:0] FLT_ZERO = 32'h00000000;
	localparam int ROOT_STEPS = 24;
	localparam logic [4:0] ROOT_LAST = 5'h17;
	localparam int SQRT_LAT_MIN = 20;
	localparam int SQRT_LAT_MAX = 30;
endpackage

// ---- sqrt_core.sv ----
// iterative restoring square root of a positive normal float
// start is taken only while the core is idle; a start while busy_ff is high is ignored
`timescale 1ns/1ps
`default_nettype none
module sqrt_core (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// request
	input wire logic start,
	input wire logic [sqrt_abs_pkg::FLT_W-1:0] radicand,
	// answer
	output logic done,
	output logic [sqrt_abs_pkg::FLT_W-1:0] root
);
	import sqrt_abs_pkg::*;
	logic busy_ff;
	logic done_ff;
	logic [4:0] cnt_ff;
	logic [47:0] rad_ff;
	logic [47:0] rad_orig_ff;
	logic [25:0] rem_ff;
	logic [23:0] root_ff;
	logic [7:0] exp_ff;
	logic [31:0] root_ff_out;
	logic [25:0] cur;
	logic [25:0] trial;
	logic [25:0] nxt_rem;
	logic [23:0] nxt_root;
	logic signed [9:0] unb;
	logic [24:0] mant25;

	// odd unbiased exponent doubles the mantissa so the halved exponent is exact
	always_comb begin
		unb = $signed({2'b00, radicand[30:23]}) - $signed(EXP_BIAS_W);
		mant25 = radicand[23] ? {2'b01, radicand[22:0]} :
			{1'b1, radicand[22:0], 1'b0};
		cur = {rem_ff[23:0], rad_ff[47:46]};
		trial = {root_ff, 2'b01};
		if (cur >= trial) begin
			nxt_rem = cur - trial;
			nxt_root = {root_ff[22:0], 1'b1};
		end else begin
			nxt_rem = cur;
			nxt_root = {root_ff[22:0], 1'b0};
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			cnt_ff <= 5'h00;
			rad_ff <= 48'h000000000000;
			rad_orig_ff <= 48'h000000000000;
			rem_ff <= 26'h0000000;
			root_ff <= 24'h000000;
			exp_ff <= 8'h00;
			root_ff_out <= FLT_ZERO;
		end else begin
			done_ff <= 1'b0;
			if (start && !busy_ff) begin
				busy_ff <= 1'b1;
				cnt_ff <= 5'h00;
				rad_ff <= {mant25, 23'h000000};
				rad_orig_ff <= {mant25[24:0], 23'h000000};
				rem_ff <= 26'h0000000;
				root_ff <= 24'h000000;
				exp_ff <= 8'(unb >>> 1) + EXP_BIAS;
			end else if (busy_ff) begin
				rad_ff <= {rad_ff[45:0], 2'b00};
				rem_ff <= nxt_rem;
				root_ff <= nxt_root;
				cnt_ff <= cnt_ff + 5'h01;
				if (cnt_ff == ROOT_LAST) begin
					busy_ff <= 1'b0;
					done_ff <= 1'b1;
					root_ff_out <= {1'b0, exp_ff, nxt_root[22:0]};
				end
			end
		end
	end

	assign done = done_ff;
	assign root = root_ff_out;

	// the truncated root squared never exceeds the radicand
	chk_root_floor: assert property (@(posedge clk) disable iff (!nrst) // RULE1
		done |-> ({24'h000000, 1'b1, root[22:0]} * {24'h000000, 1'b1,
		root[22:0]}) <= rad_orig_ff)
		else $error("root too large");
	chk_root_ceil: assert property (@(posedge clk) disable iff (!nrst) // RULE1
		done |-> (({25'h0000000, 1'b1, root[22:0]} + 49'h1) *
		({25'h0000000, 1'b1, root[22:0]} + 49'h1)) > rad_orig_ff)
		else $error("root too small");
endmodule
`default_nettype wire

// ---- sqrt_abs_unit.sv ----
// scaled square root with low cut, and magnitude with sign flags
// each exec pulse is one program execution with its start condition true
//
// Function
// RULE1 - root result is the gain times the square root of the input
// RULE2 - a scaled result at or below the low-cut level becomes zero
// RULE3 - a negative input gives zero with no root computed; the core still runs its 24 steps and the root is discarded
// RULE4 - unset low cut defaults to 0.0 and unset gain to 10.0
// RULE5 - magnitude result is the input with its sign removed
// RULE6 - positive flag for input above zero, negative flag below, none at zero
// RULE7 - special operands or overflow raise the operation error
// RULE8 - results and flags are written only by this unit
// RULE9 - evaluate once per execution, otherwise hold results and flags; a root_exec while root_busy is high is ignored
`timescale 1ns/1ps
`default_nettype none
module sqrt_abs_unit (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// root function
	input wire logic root_exec,
	input wire logic [sqrt_abs_pkg::FLT_W-1:0] root_input_value,
	input wire logic low_cut_set,
	input wire logic [sqrt_abs_pkg::FLT_W-1:0] low_cut_level,
	input wire logic gain_set,
	input wire logic [sqrt_abs_pkg::FLT_W-1:0] gain_coef,
	output logic root_busy,
	output logic root_done,
	output logic root_error,
	output logic [sqrt_abs_pkg::FLT_W-1:0] root_result_value,
	// magnitude function
	input wire logic mag_exec,
	input wire logic [sqrt_abs_pkg::FLT_W-1:0] mag_input_value,
	output logic mag_done,
	output logic mag_error,
	output logic [sqrt_abs_pkg::FLT_W-1:0] mag_result_value,
	output logic positive_flag,
	output logic negative_flag
);
	import sqrt_abs_pkg::*;
	localparam int LAT_LO = SQRT_LAT_MIN;
	localparam int LAT_HI = SQRT_LAT_MAX;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ROOT = 3'b010,
		ST_SCALE = 3'b100
	} root_state_e;

	root_state_e state_ff;
	logic accept;
	logic core_done;
	logic [31:0] core_root;
	logic [31:0] gain_ff;
	logic [31:0] cut_ff;
	logic zero_in_ff;
	logic neg_in_ff;
	logic special_ff;
	logic [31:0] root_result_ff;
	logic root_done_ff;
	logic root_error_ff;
	logic [47:0] prod;
	logic signed [10:0] prod_exp;
	logic [31:0] scaled;
	logic ovf;
	logic cut_hit;
	logic [31:0] mag_result_ff;
	logic pos_ff;
	logic neg_ff;
	logic mag_done_ff;
	logic mag_error_ff;
	logic mag_special;

	function automatic logic flt_le(input logic [31:0] a, input logic [31:0] b);
		logic r;
		r = 1'b0;
		if (a[30:0] == 31'h0 && b[30:0] == 31'h0)
			r = 1'b1;
		else if (a[31] != b[31])
			r = a[31];
		else if (!a[31])
			r = a[30:0] <= b[30:0];
		else
			r = a[30:0] >= b[30:0];
		return r;
	endfunction

	assign accept = root_exec && (state_ff == ST_IDLE); // RULE9

	sqrt_core u_core (
		.clk(clk),
		.nrst(nrst),
		.start(accept),
		.radicand(root_input_value),
		.done(core_done),
		.root(core_root)
	);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_ff <= ST_IDLE;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					if (accept)
						state_ff <= ST_ROOT;
				end
				ST_ROOT: begin
					if (core_done)
						state_ff <= ST_SCALE;
				end
				ST_SCALE: state_ff <= ST_IDLE;
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// operands are latched at acceptance so later input changes do not leak in
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gain_ff <= GAIN_DEFAULT;
			cut_ff <= LOW_CUT_DEFAULT;
			zero_in_ff <= 1'b0;
			neg_in_ff <= 1'b0;
			special_ff <= 1'b0;
		end else if (accept) begin
			gain_ff <= gain_set ? gain_coef : GAIN_DEFAULT; // RULE4
			cut_ff <= low_cut_set ? low_cut_level : LOW_CUT_DEFAULT; // RULE4
			zero_in_ff <= root_input_value[30:23] == 8'h00;
			neg_in_ff <= root_input_value[31]; // RULE3
			special_ff <= root_input_value[30:23] == EXP_SPECIAL ||
				(gain_set && gain_coef[30:23] == EXP_SPECIAL) ||
				(low_cut_set && low_cut_level[30:23] == EXP_SPECIAL); // RULE7
		end
	end

	// gain times root; subnormal gains flush to zero
	always_comb begin
		prod = {1'b1, core_root[22:0]} * {1'b1, gain_ff[22:0]};
		prod_exp = $signed({3'b000, core_root[30:23]}) +
			$signed({3'b000, gain_ff[30:23]}) -
			$signed({1'b0, EXP_BIAS_W}) + (prod[47] ? 11'sd1 : 11'sd0);
		ovf = 1'b0;
		scaled = FLT_ZERO;
		if (gain_ff[30:23] == 8'h00 || prod_exp <= 11'sd0) begin
			scaled = FLT_ZERO;
		end else if (prod_exp >= 11'sd255) begin
			ovf = 1'b1; // RULE7
		end else begin
			scaled = {gain_ff[31], prod_exp[7:0],
				prod[47] ? prod[46:24] : prod[45:23]}; // RULE1
		end
		cut_hit = flt_le(scaled, cut_ff); // RULE2
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			root_result_ff <= FLT_ZERO;
			root_done_ff <= 1'b0;
			root_error_ff <= 1'b0;
		end else begin
			root_done_ff <= state_ff == ST_SCALE;
			if (state_ff == ST_SCALE) begin
				root_error_ff <= special_ff || (ovf && !neg_in_ff && !zero_in_ff);
				if (special_ff) begin
					root_result_ff <= root_result_ff;
				end else if (neg_in_ff || zero_in_ff) begin
					root_result_ff <= FLT_ZERO; // RULE3
				end else if (ovf) begin
					root_result_ff <= root_result_ff; // RULE7
				end else if (cut_hit) begin
					root_result_ff <= FLT_ZERO; // RULE2
				end else begin
					root_result_ff <= scaled; // RULE1
				end
			end
		end
	end

	assign mag_special = mag_input_value[30:23] == EXP_SPECIAL;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mag_result_ff <= FLT_ZERO;
			pos_ff <= 1'b0;
			neg_ff <= 1'b0;
			mag_done_ff <= 1'b0;
			mag_error_ff <= 1'b0;
		end else begin
			mag_done_ff <= mag_exec;
			if (mag_exec) begin // RULE9
				mag_error_ff <= mag_special; // RULE7
				if (!mag_special) begin
					mag_result_ff <= {1'b0, mag_input_value[30:0]}; // RULE5
					pos_ff <= !mag_input_value[31] &&
						mag_input_value[30:0] != 31'h0; // RULE6
					neg_ff <= mag_input_value[31] &&
						mag_input_value[30:0] != 31'h0; // RULE6
				end
			end
		end
	end

	// outputs are flip-flops, except root_busy decoded from state_ff, with no write path from outside
	assign root_result_value = root_result_ff; // RULE8
	assign root_done = root_done_ff;
	assign root_error = root_error_ff;
	assign root_busy = state_ff != ST_IDLE;
	assign mag_result_value = mag_result_ff; // RULE8
	assign positive_flag = pos_ff;
	assign negative_flag = neg_ff;
	assign mag_done = mag_done_ff;
	assign mag_error = mag_error_ff;

	chk_root_latency: assert property (@(posedge clk) disable iff (!nrst) // RULE9
		accept |-> ##[LAT_LO:LAT_HI] root_done)
		else $error("root result late");
	chk_root_hold: assert property (@(posedge clk) disable iff (!nrst) // RULE9
		!root_done |-> $stable(root_result_value))
		else $error("root result changed without execution");
	chk_neg_zero: assert property (@(posedge clk) disable iff (!nrst) // RULE3
		accept && root_input_value[31] &&
		root_input_value[30:23] != EXP_SPECIAL &&
		!(gain_set && gain_coef[30:23] == EXP_SPECIAL) &&
		!(low_cut_set && low_cut_level[30:23] == EXP_SPECIAL) |->
		##[LAT_LO:LAT_HI] (root_done && root_result_value == 32'h0))
		else $error("negative input not zeroed");
	chk_low_cut: assert property (@(posedge clk) disable iff (!nrst) // RULE2
		state_ff == ST_SCALE && !special_ff && !ovf && cut_hit |=>
		root_result_value == 32'h0)
		else $error("low cut not applied");
	chk_gain_default: assert property (@(posedge clk) disable iff (!nrst) // RULE4
		accept && !gain_set && !low_cut_set |=>
		gain_ff == 32'h41200000 && cut_ff == 32'h0)
		else $error("default constants not used");
	chk_special_error: assert property (@(posedge clk) disable iff (!nrst) // RULE7
		accept && root_input_value[30:23] == 8'hFF |->
		##[LAT_LO:LAT_HI] (root_done && root_error))
		else $error("special operand not flagged");
	chk_mag_value: assert property (@(posedge clk) disable iff (!nrst) // RULE5
		mag_exec && !mag_special |=>
		mag_done && mag_result_value == {1'b0, $past(mag_input_value[30:0])})
		else $error("magnitude wrong");
	chk_flag_sign: assert property (@(posedge clk) disable iff (!nrst) // RULE6
		mag_exec && !mag_special && mag_input_value[31] &&
		mag_input_value[30:0] != 31'h0 |=> negative_flag && !positive_flag)
		else $error("negative flag wrong");
	chk_flag_excl: assert property (@(posedge clk) disable iff (!nrst) // RULE6
		!(positive_flag && negative_flag))
		else $error("both sign flags set");
	chk_mag_hold: assert property (@(posedge clk) disable iff (!nrst) // RULE9
		!$past(mag_exec) |-> $stable(mag_result_value) && $stable(positive_flag))
		else $error("magnitude changed without execution");
endmodule
`default_nettype wire

// ---- sqrt_abs_unit_bench.sv ----
// self-checking bench for the square-root and magnitude unit
// assumes the unit's fixed 26-cycle root latency and 1-cycle magnitude
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin n_errors++; \
	$display("wrong value at %0t: %s", $time, m); end end
module sqrt_abs_unit_bench;
	import sqrt_abs_pkg::*;
	logic clk = 1'b0;
	logic nrst, root_exec, low_cut_set, gain_set, mag_exec;
	logic [FLT_W-1:0] root_in, lc_in, gain_in, mag_in, root_res, mag_res;
	logic root_busy, root_done, root_error, mag_done, mag_error, pos_f, neg_f;
	int n_errors = 0;
	int checks = 0;
	int k;
	logic [31:0] seed = 32'h00000039;
	logic [31:0] last_root = 32'h00000000;
	logic [31:0] last_mag = 32'h00000000;
	logic last_p = 1'b0;
	logic last_n = 1'b0;
	logic [32:0] rq[$];
	logic [34:0] mq[$];
	logic [32:0] rexp;
	logic [34:0] mexp;
	sqrt_abs_unit i_dut (.clk(clk), .nrst(nrst), .root_exec(root_exec),
		.root_input_value(root_in), .low_cut_set(low_cut_set),
		.low_cut_level(lc_in), .gain_set(gain_set), .gain_coef(gain_in),
		.root_busy(root_busy), .root_done(root_done), .root_error(root_error),
		.root_result_value(root_res), .mag_exec(mag_exec),
		.mag_input_value(mag_in), .mag_done(mag_done), .mag_error(mag_error),
		.mag_result_value(mag_res), .positive_flag(pos_f),
		.negative_flag(neg_f));
	always #2.5 clk = ~clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// exact float encoding of a small positive integer
	function automatic logic [31:0] i2f(input int v);
		int p;
		logic [31:0] m;
		p = 0;
		for (int i = 0; i < 31; i++)
			if (v[i])
				p = i;
		m = 32'(v) << (23 - p);
		return {1'b0, 8'(127 + p), m[22:0]};
	endfunction
	task final_report;
		if (n_errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// a refused or extra execution shows up as a done with nothing queued
	always @(posedge clk) begin
		if (root_done === 1'b1) begin
			if (rq.size() == 0) `CHK(1'b1, 1'b0, "extra root done")
			else begin
				rexp = rq.pop_front();
				`CHK(root_res, rexp[31:0], "root result")
				`CHK(root_error, rexp[32], "root error")
			end
		end
		if (mag_done === 1'b1) begin
			if (mq.size() == 0) `CHK(1'b1, 1'b0, "extra mag done")
			else begin
				mexp = mq.pop_front();
				`CHK(mag_res, mexp[31:0], "magnitude")
				`CHK({pos_f, neg_f}, mexp[33:32], "sign flags")
				`CHK(mag_error, mexp[34], "mag error")
			end
		end
	end
	task automatic root(input logic [31:0] v, input logic ls,
		input logic [31:0] l, input logic gs, input logic [31:0] g,
		input logic [31:0] r, input logic e);
		int n;
		root_in = v;
		low_cut_set = ls;
		lc_in = l;
		gain_set = gs;
		gain_in = g;
		root_exec = 1'b1;
		if (e)
			r = last_root;
		last_root = r;
		rq.push_back({e, r});
		@(posedge clk);
		#1 root_exec = 1'b0;
		n = 0;
		while (root_done !== 1'b1) begin
			@(posedge clk);
			#1 n++;
			if (n == 1) `CHK(root_busy, 1'b1, "not busy")
			// a request while busy must be ignored
			if (n == 5) begin
				root_exec = 1'b1;
				root_in = 32'h41800000;
			end
			if (n == 6)
				root_exec = 1'b0;
			if (n > 40) begin
				n_errors++;
				final_report();
			end
		end
		`CHK(n, 26, "root latency")
	endtask
	task automatic mag(input logic [31:0] v);
		logic z;
		z = (v[30:0] != 31'h00000000);
		mag_in = v;
		mag_exec = 1'b1;
		if (v[30:23] == EXP_SPECIAL)
			mq.push_back({1'b1, last_p, last_n, last_mag});
		else begin
			last_mag = {1'b0, v[30:0]};
			last_p = !v[31] && z;
			last_n = v[31] && z;
			mq.push_back({1'b0, last_p, last_n, last_mag});
		end
		@(posedge clk);
		#1;
	endtask
	initial begin
		{nrst, root_exec, low_cut_set, gain_set, mag_exec} = 5'h00;
		{root_in, lc_in, gain_in, mag_in} = 128'h0;
		repeat (20) @(posedge clk);
		#1 nrst = 1'b1;
		root(32'h41800000, 1'b0, 32'h0, 1'b0, 32'h0, 32'h42200000, 1'b0);
		root(32'h41100000, 1'b0, 32'h0, 1'b1, 32'h40000000, 32'h40C00000, 1'b0);
		root(32'h7F800000, 1'b0, 32'h0, 1'b0, 32'h0, 32'h0, 1'b1);
		root(32'h41800000, 1'b0, 32'h0, 1'b1, 32'h7F800000, 32'h0, 1'b1);
		root(32'h41800000, 1'b1, 32'h7FC00000, 1'b0, 32'h0, 32'h0, 1'b1);
		root(32'h41800000, 1'b0, 32'h0, 1'b1, 32'h7F000000, 32'h0, 1'b1);
		root(32'h00000000, 1'b0, 32'h0, 1'b0, 32'h0, 32'h0, 1'b0);
		root(32'h41100000, 1'b1, 32'h40C00000, 1'b1, 32'h40000000, 32'h0, 1'b0);
		root(32'h41100000, 1'b1, 32'h40A00000, 1'b1, 32'h40000000, 32'h40C00000,
			1'b0);
		root(32'hC0800000, 1'b0, 32'h0, 1'b0, 32'h0, 32'h0, 1'b0);
		root(32'h41800000, 1'b0, 32'h0, 1'b1, 32'hBF800000, 32'h0, 1'b0);
		repeat (4) begin
			k = int'(rnd() % 32'h000000FF) + 1;
			root(i2f(k * k), 1'b0, rnd(), 1'b1, 32'h3F800000,
				i2f(k), 1'b0);
		end
		mag(32'h00000000);
		mag(32'h80000000);
		mag(32'hC1200000);
		mag(32'h7F800000);
		mag(32'h41200000);
		repeat (40) mag(rnd());
		mag_exec = 1'b0;
		repeat (5) @(posedge clk);
		#1;
		`CHK(root_res, last_root, "root not held")
		`CHK(mag_res, last_mag, "magnitude not held")
		`CHK(rq.size() + mq.size(), 0, "missing done")
		final_report();
	end
endmodule
`default_nettype wire
